/* File: logic/flash_readback_pkg.sv */
// Purpose: Shared constants and types for the settings readback block
// Assumes: Byte indices and field positions of the stored settings reply
// Notes: Codes for the three pin function fields live here too
package flash_readback_pkg;
  localparam logic [7:0] CMD_READ_FLASH = 8'hB0;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [5:0] IDX_CODE = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_LEN = 6'h02;
  localparam logic [5:0] IDX_PIN0 = 6'h04;
  localparam logic [5:0] IDX_PIN1 = 6'h05;
  localparam logic [5:0] IDX_PIN2 = 6'h06;
  localparam logic [5:0] IDX_ANALOG = 6'h07;
  localparam logic [5:0] IDX_VID_LO = 6'h08;
  localparam logic [5:0] IDX_VID_HI = 6'h09;
  localparam logic [5:0] IDX_PID_LO = 6'h0A;
  localparam logic [5:0] IDX_PID_HI = 6'h0B;
  localparam logic [5:0] IDX_POWER = 6'h0C;
  localparam logic [5:0] IDX_CURRENT = 6'h0D;
  localparam logic [5:0] IDX_LAST = 6'h3F;
  // Analog byte fields
  localparam int BIT_NEG_EDGE = 6;
  localparam int BIT_POS_EDGE = 5;
  localparam int BIT_ADC_REF_HI = 4;
  localparam int BIT_ADC_REF_LO = 3;
  localparam int BIT_DAC_SUPPLY = 2;
  localparam logic [7:0] ANALOG_KEEP = 8'h7C;
  localparam logic [1:0] ADC_REF_OFF = 2'h0;
  // Indicator initial level byte fields
  localparam int BIT_LED_RX = 6;
  localparam int BIT_LED_TX = 5;
  localparam int BIT_LED_SUSPEND = 3;
  localparam int BIT_LED_CFG = 2;
  // Pin settings byte fields
  localparam int BIT_OUT_LEVEL = 4;
  localparam int BIT_DIR_IN = 3;
  localparam logic [7:0] PIN_KEEP = 8'h1F;
  localparam logic [2:0] FN_GPIO = 3'h0;
  localparam logic [2:0] FN_DEDICATED = 3'h1;
  localparam logic [2:0] FN_ALT0 = 3'h2;
  localparam logic [2:0] FN_ALT1 = 3'h3;
  localparam logic [2:0] FN_ALT2 = 3'h4;
  // Reply sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } reply_state_e;
endpackage : flash_readback_pkg

/* File: logic/flash_settings_readback.sv */
// Purpose: Builds the 64-byte settings replies and applies power-up settings
// Assumes: Stored settings are stable while nrst is low and are captured then
// Notes: One reply byte per clock after a request; requests while busy drop
`timescale 1ns/1ps
`default_nettype none
module flash_settings_readback #(
  parameter logic [7:0] CHIP_LEN = 8'h3C,
  parameter logic [7:0] PIN_LEN = 8'h3C
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Reply request and byte stream
  input wire logic req,
  input wire logic req_pins,
  output logic busy,
  output logic rsp_valid,
  output logic [5:0] rsp_index,
  output logic [7:0] rsp_data,
  output logic rsp_last,
  // Stored settings, captured while in reset
  input wire logic [7:0] nv_led_init,
  input wire logic [7:0] nv_analog,
  input wire logic [15:0] nv_vid,
  input wire logic [15:0] nv_pid,
  input wire logic [7:0] nv_power,
  input wire logic [7:0] nv_current,
  input wire logic [7:0] nv_pin_zero,
  input wire logic [7:0] nv_pin_one,
  input wire logic [7:0] nv_pin_two,
  // Live device status
  input wire logic suspended,
  input wire logic usb_configured,
  input wire logic rx_busy,
  input wire logic tx_busy,
  input wire logic clk_div,
  // Interrupt detection flag
  input wire logic int_clear,
  output logic int_flag,
  // Applied settings
  output logic [1:0] adc_ref_sel,
  output logic adc_ref_on,
  output logic dac_ref_supply,
  output logic [7:0] usb_power_attr,
  output logic [8:0] usb_current_ma,
  // Pins zero to two
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [2:0] analog_in_en,
  output logic analog_out_en
);
  typedef struct packed {
    flash_readback_pkg::reply_state_e state;
    logic pins;
    logic [5:0] idx;
    logic valid;
    logic [5:0] out_idx;
    logic [7:0] data;
    logic last;
    logic [7:0] led_init;
    logic [7:0] analog;
    logic [15:0] vid;
    logic [15:0] pid;
    logic [7:0] power;
    logic [7:0] current;
    logic [23:0] pin_set;
    logic int_prev;
    logic int_flag;
  } top_s;

  top_s st_r;
  top_s st_nxt;

  pin_cfg_if pc ();

  // Reply content for one index; unlisted indices read as fill
  function automatic logic [7:0] reply_byte(input top_s s,
      input logic [5:0] i);
    logic [7:0] b;
    b = flash_readback_pkg::FILL_BYTE;
    if (i == flash_readback_pkg::IDX_CODE) begin
      b = flash_readback_pkg::CMD_READ_FLASH;
    end else if (i == flash_readback_pkg::IDX_STATUS) begin
      b = flash_readback_pkg::STATUS_OK;
    end else if (i == flash_readback_pkg::IDX_LEN) begin
      b = s.pins ? PIN_LEN : CHIP_LEN;
    end else if (s.pins) begin
      // Don't-care high bits zeroed so the reply is repeatable
      if (i == flash_readback_pkg::IDX_PIN0) begin
        b = s.pin_set[7:0] & flash_readback_pkg::PIN_KEEP;
      end else if (i == flash_readback_pkg::IDX_PIN1) begin
        b = s.pin_set[15:8] & flash_readback_pkg::PIN_KEEP;
      end else if (i == flash_readback_pkg::IDX_PIN2) begin
        b = s.pin_set[23:16] & flash_readback_pkg::PIN_KEEP;
      end
    end else if (i == flash_readback_pkg::IDX_ANALOG) begin
      b = s.analog & flash_readback_pkg::ANALOG_KEEP;
    end else if (i == flash_readback_pkg::IDX_VID_LO) begin
      b = s.vid[7:0];
    end else if (i == flash_readback_pkg::IDX_VID_HI) begin
      b = s.vid[15:8];
    end else if (i == flash_readback_pkg::IDX_PID_LO) begin
      b = s.pid[7:0];
    end else if (i == flash_readback_pkg::IDX_PID_HI) begin
      b = s.pid[15:8];
    end else if (i == flash_readback_pkg::IDX_POWER) begin
      b = s.power;
    end else if (i == flash_readback_pkg::IDX_CURRENT) begin
      b = s.current;
    end
    return b;
  endfunction : reply_byte

  always_comb begin
    logic rise;
    logic fall;
    st_nxt = st_r;
    rise = pc.int_level & ~st_r.int_prev;
    fall = ~pc.int_level & st_r.int_prev;
    st_nxt.int_prev = pc.int_level;
    st_nxt.valid = 1'b0;
    st_nxt.last = 1'b0;
    case (st_r.state)
      flash_readback_pkg::ST_IDLE: begin
        if (req) begin
          st_nxt.state = flash_readback_pkg::ST_SEND;
          st_nxt.pins = req_pins;
          st_nxt.idx = '0;
        end
      end
      flash_readback_pkg::ST_SEND: begin
        st_nxt.valid = 1'b1;
        st_nxt.out_idx = st_r.idx;
        st_nxt.data = reply_byte(st_r, st_r.idx);
        st_nxt.idx = st_r.idx + 6'h01;
        if (st_r.idx == flash_readback_pkg::IDX_LAST) begin
          st_nxt.last = 1'b1;
          st_nxt.state = flash_readback_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt.state = flash_readback_pkg::ST_IDLE;
      end
    endcase
    // Clear first, so an edge in the same cycle still sets the flag
    if (int_clear) begin
      st_nxt.int_flag = 1'b0;
    end
    if (fall && st_r.analog[flash_readback_pkg::BIT_NEG_EDGE]) begin
      st_nxt.int_flag = 1'b1;
    end
    if (rise && st_r.analog[flash_readback_pkg::BIT_POS_EDGE]) begin
      st_nxt.int_flag = 1'b1;
    end
    if (!nrst) begin
      st_nxt = '0;
      st_nxt.state = flash_readback_pkg::ST_IDLE;
      st_nxt.led_init = nv_led_init;
      st_nxt.analog = nv_analog;
      st_nxt.vid = nv_vid;
      st_nxt.pid = nv_pid;
      st_nxt.power = nv_power;
      st_nxt.current = nv_current;
      st_nxt.pin_set = {nv_pin_two, nv_pin_one, nv_pin_zero};
    end
  end

  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  // Stored snapshot feeds the pin logic
  assign pc.pin_set[0] = st_r.pin_set[7:0];
  assign pc.pin_set[1] = st_r.pin_set[15:8];
  assign pc.pin_set[2] = st_r.pin_set[23:16];
  assign pc.suspend_init = st_r.led_init[flash_readback_pkg::BIT_LED_SUSPEND];
  assign pc.cfg_init = st_r.led_init[flash_readback_pkg::BIT_LED_CFG];
  assign pc.rx_init = st_r.led_init[flash_readback_pkg::BIT_LED_RX];
  assign pc.tx_init = st_r.led_init[flash_readback_pkg::BIT_LED_TX];
  assign pc.suspended = suspended;
  assign pc.usb_configured = usb_configured;
  assign pc.rx_busy = rx_busy;
  assign pc.tx_busy = tx_busy;
  assign pc.clk_div = clk_div;
  assign pc.pin_in = pin_in;

  pin_function_mux u_pins (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pc(pc.pins)
  );

  assign pin_out = pc.pin_out;
  assign pin_oe = pc.pin_oe;
  assign analog_in_en = pc.analog_in_en;
  assign analog_out_en = pc.analog_out_en;

  assign busy = st_r.state != flash_readback_pkg::ST_IDLE;
  assign rsp_valid = st_r.valid;
  assign rsp_index = st_r.out_idx;
  assign rsp_data = st_r.data;
  assign rsp_last = st_r.last;
  assign int_flag = st_r.int_flag;
  assign adc_ref_sel = st_r.analog[flash_readback_pkg::BIT_ADC_REF_HI:
    flash_readback_pkg::BIT_ADC_REF_LO];
  // Code 00 leaves the converter on an external reference
  assign adc_ref_on = adc_ref_sel != flash_readback_pkg::ADC_REF_OFF;
  assign dac_ref_supply = st_r.analog[flash_readback_pkg::BIT_DAC_SUPPLY];
  assign usb_power_attr = st_r.power;
  assign usb_current_ma = {st_r.current, 1'b0};
endmodule : flash_settings_readback
`default_nettype wire

/* File: logic/pin_cfg_if.sv */
// Purpose: Carries pin settings and live status between top and pin logic
// Assumes: One clock, all fields synchronous
// Notes: Top fills settings and status, pin logic returns drive values
`timescale 1ns/1ps
`default_nettype none
interface pin_cfg_if;
  logic [7:0] pin_set [3];
  logic suspend_init;
  logic cfg_init;
  logic rx_init;
  logic tx_init;
  logic suspended;
  logic usb_configured;
  logic rx_busy;
  logic tx_busy;
  logic clk_div;
  logic [2:0] pin_in;
  logic [2:0] pin_out;
  logic [2:0] pin_oe;
  logic [2:0] analog_in_en;
  logic analog_out_en;
  logic int_level;
  modport top (output pin_set, suspend_init, cfg_init, rx_init, tx_init,
    suspended, usb_configured, rx_busy, tx_busy, clk_div, pin_in,
    input pin_out, pin_oe, analog_in_en, analog_out_en, int_level);
  modport pins (input pin_set, suspend_init, cfg_init, rx_init, tx_init,
    suspended, usb_configured, rx_busy, tx_busy, clk_div, pin_in,
    output pin_out, pin_oe, analog_in_en, analog_out_en, int_level);
endinterface : pin_cfg_if
`default_nettype wire

/* File: logic/pin_function_mux.sv */
// Purpose: Drives pins zero to two from their power-up settings bytes
// Assumes: Settings bytes are stable snapshots taken at reset
// Notes: Drive outputs are registered, int_level is not; pin inputs are synchronous
`timescale 1ns/1ps
`default_nettype none
module pin_function_mux (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Settings and status
  pin_cfg_if.pins pc
);
  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
    logic [2:0] ain;
    logic aout;
  } mux_s;

  mux_s st_r;
  mux_s st_nxt;

  always_comb begin
    logic [2:0] fn [3];
    fn = '{default: flash_readback_pkg::FN_GPIO};
    st_nxt = '0;
    for (int i = 0; i < 3; i++) begin
      fn[i] = pc.pin_set[i][2:0];
      // Direction only matters for plain GPIO
      if (fn[i] == flash_readback_pkg::FN_GPIO) begin
        st_nxt.oe[i] = ~pc.pin_set[i][flash_readback_pkg::BIT_DIR_IN];
        st_nxt.out[i] = pc.pin_set[i][flash_readback_pkg::BIT_OUT_LEVEL];
      end
    end
    // Pin zero
    if (fn[0] == flash_readback_pkg::FN_DEDICATED) begin
      st_nxt.oe[0] = 1'b1;
      st_nxt.out[0] = pc.suspend_init ^ pc.suspended;
    end else if (fn[0] == flash_readback_pkg::FN_ALT0) begin
      st_nxt.oe[0] = 1'b1;
      st_nxt.out[0] = pc.rx_init ^ pc.rx_busy;
    end
    // Pin one
    if (fn[1] == flash_readback_pkg::FN_DEDICATED) begin
      st_nxt.oe[1] = 1'b1;
      st_nxt.out[1] = pc.clk_div;
    end else if (fn[1] == flash_readback_pkg::FN_ALT0) begin
      st_nxt.ain[1] = 1'b1;
    end else if (fn[1] == flash_readback_pkg::FN_ALT1) begin
      st_nxt.oe[1] = 1'b1;
      st_nxt.out[1] = pc.tx_init ^ pc.tx_busy;
    end
    // Pin two
    if (fn[2] == flash_readback_pkg::FN_DEDICATED) begin
      st_nxt.oe[2] = 1'b1;
      st_nxt.out[2] = pc.cfg_init ^ pc.usb_configured;
    end else if (fn[2] == flash_readback_pkg::FN_ALT0) begin
      st_nxt.ain[2] = 1'b1;
    end else if (fn[2] == flash_readback_pkg::FN_ALT1) begin
      st_nxt.aout = 1'b1;
    end
    if (!nrst) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    st_r <= st_nxt;
  end

  assign pc.pin_out = st_r.out;
  assign pc.pin_oe = st_r.oe;
  assign pc.analog_in_en = st_r.ain;
  assign pc.analog_out_en = st_r.aout;
  // Edge detector only sees pin one when it is the interrupt input
  assign pc.int_level = (pc.pin_set[1][2:0] == flash_readback_pkg::FN_ALT2)
    & pc.pin_in[1];
endmodule : pin_function_mux
`default_nettype wire

/* File: test/host_model.sv */
// Purpose: Host side that asks for a settings reply and keeps its bytes
// Assumes: Called only while the block is idle
// Notes: A poke re-asks mid-reply, which the block must ignore
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic ref_clk,
  // Reply stream
  input wire logic busy,
  input wire logic rsp_valid,
  input wire logic rsp_last,
  input wire logic [5:0] rsp_index,
  input wire logic [7:0] rsp_data,
  // Request
  output logic req,
  output logic req_pins
);
  logic [7:0] got [64];
  int n_got;
  initial begin
    req = 1'b0;
    req_pins = 1'b0;
  end
  task automatic read_reply(input logic pins, input logic poke);
    int i;
    req = 1'b1;
    req_pins = pins;
    @(negedge ref_clk);
    req = 1'b0;
    n_got = 0;
    for (i = 0; i < 80; i++) begin
      @(negedge ref_clk);
      // Flipped kind too, so a wrongly taken poke shows in the bytes
      req = poke && (i == 10);
      req_pins = (i == 10) ? !pins : pins;
      if (rsp_valid) begin
        got[rsp_index] = rsp_data;
        n_got++;
      end
      if (rsp_valid && rsp_last) break;
    end
    req = 1'b0;
  endtask : read_reply
endmodule : host_model
`default_nettype wire

/* File: test/readback_asserts.sv */
// Purpose: Port checks for the settings readback block
// Assumes: Stored settings change only together with a reset
// Notes: Reply kind is remembered from the accepted request
`timescale 1ns/1ps
`default_nettype none
module readback_asserts (
  // Clock, reset, request
  input wire logic ref_clk, nrst, req, req_pins, busy,
  // Reply stream
  input wire logic rsp_valid, rsp_last,
  input wire logic [5:0] rsp_index,
  input wire logic [7:0] rsp_data,
  // Stored settings
  input wire logic [7:0] nv_led_init, nv_analog, nv_power, nv_current,
  input wire logic [15:0] nv_vid, nv_pid,
  input wire logic [7:0] nv_pin_zero, nv_pin_one, nv_pin_two,
  // Status and applied outputs
  input wire logic suspended, usb_configured, int_flag,
  input wire logic [2:0] pin_in, pin_out,
  input wire logic [1:0] adc_ref_sel,
  input wire logic adc_ref_on, dac_ref_supply,
  input wire logic [7:0] usb_power_attr,
  input wire logic [8:0] usb_current_ma
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic pins_r;
  always_ff @(posedge ref_clk) begin
    if (req && !busy) pins_r <= req_pins;
  end
  sequence lead_s;
    busy ##1 rsp_valid && rsp_index == 6'h00 && rsp_data == 8'hB0;
  endsequence
  sequence ok_s;
    rsp_valid && rsp_index == 6'h01 && rsp_data == 8'h00;
  endsequence
  reply_head_a: assert property (req && !busy |=> lead_s ##1 ok_s)
    else $error("reply header wrong");
  reply_frame_a: assert property (rsp_valid && rsp_index == 6'h00 |->
    ##63 rsp_valid && rsp_last && rsp_index == 6'h3F ##1 !rsp_valid)
    else $error("reply frame wrong");
  vid_pair_a: assert property (rsp_valid && !pins_r && rsp_index == 6'h08
    |-> rsp_data == nv_vid[7:0] ##1 rsp_data == nv_vid[15:8])
    else $error("vendor id bytes wrong");
  pid_pair_a: assert property (rsp_valid && !pins_r && rsp_index == 6'h0A
    |-> rsp_data == nv_pid[7:0] ##1 rsp_data == nv_pid[15:8])
    else $error("product id bytes wrong");
  enum_power_a: assert property (usb_power_attr == nv_power &&
    usb_current_ma == {nv_current, 1'b0}) else $error("power values wrong");
  ref_select_a: assert property (adc_ref_sel == nv_analog[4:3] &&
    adc_ref_on == (nv_analog[4:3] != 2'h0) && dac_ref_supply == nv_analog[2])
    else $error("reference select wrong");
  pin_fill_a: assert property (rsp_valid && pins_r && rsp_index > 6'h06
    |-> rsp_data == 8'h00) else $error("pin reply fill not zero");
  rise_flag_a: assert property (nv_pin_one[2:0] == 3'h4 && nv_analog[5]
    && $rose(pin_in[1]) |-> ##[1:2] int_flag) else $error("rise missed");
  fall_flag_a: assert property (nv_pin_one[2:0] == 3'h4 && nv_analog[6]
    && $fell(pin_in[1]) |-> ##[1:2] int_flag) else $error("fall missed");
  suspend_led_a: assert property ($past(nrst) && nv_pin_zero[2:0] == 3'h1
    |-> pin_out[0] == (nv_led_init[3] ^ $past(suspended)))
    else $error("suspend indicator wrong");
  config_led_a: assert property ($past(nrst) && nv_pin_two[2:0] == 3'h1
    |-> pin_out[2] == (nv_led_init[2] ^ $past(usb_configured)))
    else $error("configured indicator wrong");
endmodule : readback_asserts
bind flash_settings_readback readback_asserts chk (.*);
`default_nettype wire

/* File: test/testbench.sv */
// Purpose: Self-checking bench for the settings readback block
// Assumes: Settings change only with a reset, inputs move at falling edge
// Notes: Each scenario resets with its own stored settings
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] CHIP_L = 8'h3A;
  localparam logic [7:0] PIN_L = 8'h2C;
  logic ref_clk, nrst, req, req_pins, busy, rsp_valid, rsp_last, int_clear;
  logic suspended, usb_configured, rx_busy, tx_busy, clk_div, int_flag;
  logic adc_ref_on, dac_ref_supply, analog_out_en;
  logic [5:0] rsp_index;
  logic [7:0] rsp_data, nv_led_init, nv_analog, nv_power, nv_current;
  logic [7:0] nv_pin_zero, nv_pin_one, nv_pin_two, usb_power_attr;
  logic [15:0] nv_vid, nv_pid;
  logic [8:0] usb_current_ma;
  logic [1:0] adc_ref_sel;
  logic [2:0] pin_in, pin_out, pin_oe, analog_in_en;
  logic [7:0] exp_b [64];
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  flash_settings_readback #(.CHIP_LEN(CHIP_L), .PIN_LEN(PIN_L)) uut (.*);
  host_model host (.*);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic chk(input logic [8:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Settings and nrst move in one time step, so no edge sees a mix
  task automatic do_reset();
    nrst = 1'b0;
    {suspended, usb_configured, rx_busy, tx_busy, clk_div} = 5'h00;
    {int_clear, pin_in} = 4'h0;
    repeat (8) @(negedge ref_clk);
    nrst = 1'b1;
    @(negedge ref_clk);
  endtask : do_reset
  task automatic chk_reply(input logic pins);
    int i;
    host.read_reply(pins, 1'b1);
    repeat (3) @(negedge ref_clk);
    chk(rsp_valid, 1'b0, "poke restarted reply");
    chk(9'(host.n_got), 9'h040, "byte count");
    for (i = 0; i < 64; i++) chk(host.got[i], exp_b[i], "reply byte");
  endtask : chk_reply
  task automatic t_chip();
    int c;
    for (c = 0; c < 4; c++) begin
      nv_analog = 8'h83 | 8'(c << 3) | (c[0] ? 8'h04 : 8'h00);
      do_reset();
      chk(adc_ref_sel, c[1:0], "adc ref code");
      chk(adc_ref_on, c != 0, "adc ref on");
      chk(dac_ref_supply, c[0], "dac ref");
    end
    chk(usb_power_attr, 8'hA5, "power attr");
    chk(usb_current_ma, 9'h1F4, "current");
    exp_b = '{default: 8'h00};
    exp_b[0] = 8'hB0;
    exp_b[2] = CHIP_L;
    exp_b[7] = nv_analog & 8'h7C;
    {exp_b[9], exp_b[8], exp_b[11], exp_b[10]} = {nv_vid, nv_pid};
    {exp_b[12], exp_b[13]} = {nv_power, nv_current};
    chk_reply(1'b0);
    $display("test chip reply done");
  endtask : t_chip
  task automatic t_pins();
    {nv_pin_zero, nv_pin_one, nv_pin_two} = {8'hF0, 8'hE8, 8'h03};
    do_reset();
    exp_b = '{default: 8'h00};
    exp_b[0] = 8'hB0;
    exp_b[2] = PIN_L;
    {exp_b[4], exp_b[5], exp_b[6]} = {8'h10, 8'h08, 8'h03};
    chk_reply(1'b1);
    chk(pin_oe[1:0], 2'b01, "gpio direction");
    chk(pin_out[0], 1'b1, "gpio level");
    chk(analog_out_en, 1'b1, "analog out");
    {nv_pin_zero, nv_pin_one, nv_pin_two} = {8'h18, 8'h02, 8'h02};
    do_reset();
    chk(pin_oe[0], 1'b0, "input ignores level");
    chk(analog_in_en[2:1], 2'b11, "analog ins");
    $display("test pin reply done");
  endtask : t_pins
  task automatic t_ind();
    {nv_led_init, nv_pin_zero, nv_pin_one, nv_pin_two} = 32'h6C020301;
    do_reset();
    chk(pin_out, 3'h7, "indicators idle");
    {rx_busy, tx_busy, usb_configured} = 3'h7;
    repeat (2) @(negedge ref_clk);
    chk(pin_out, 3'h0, "indicators active");
    {nv_pin_zero, nv_pin_one} = {8'h01, 8'h01};
    do_reset();
    {suspended, clk_div} = 2'h3;
    repeat (2) @(negedge ref_clk);
    chk(pin_out[1:0], 2'b10, "suspend and clock");
    $display("test indicators done");
  endtask : t_ind
  task automatic t_int();
    {nv_pin_one, nv_analog} = {8'h04, 8'h40};
    do_reset();
    pin_in = 3'h2;
    repeat (3) @(negedge ref_clk);
    chk(int_flag, 1'b0, "rise not selected");
    pin_in = 3'h0;
    repeat (3) @(negedge ref_clk);
    chk(int_flag, 1'b1, "fall flag");
    int_clear = 1'b1;
    @(negedge ref_clk);
    int_clear = 1'b0;
    @(negedge ref_clk);
    chk(int_flag, 1'b0, "flag cleared");
    nv_analog = 8'h20;
    do_reset();
    pin_in = 3'h2;
    repeat (3) @(negedge ref_clk);
    chk(int_flag, 1'b1, "rise flag");
    // Edge and clear in one cycle: the edge must win
    int_clear = 1'b1;
    pin_in = 3'h0;
    @(negedge ref_clk);
    chk(int_flag, 1'b0, "clear with no edge");
    pin_in = 3'h2;
    @(negedge ref_clk);
    int_clear = 1'b0;
    chk(int_flag, 1'b1, "set beats clear");
    $display("test interrupt done");
  endtask : t_int
  initial begin
    {nv_led_init, nv_analog, nv_power, nv_current} = 32'h0000A5FA;
    {nv_vid, nv_pid} = {16'h1234, 16'hABCD};
    {nv_pin_zero, nv_pin_one, nv_pin_two} = 24'h000000;
    t_chip();
    t_pins();
    t_ind();
    t_int();
    results();
  end
endmodule : testbench
`default_nettype wire
